// ---- rtl/spc_map.vh ----
// spc_map.vh: constants for the switch port strap configuration block
// assumes inclusion by bare name from the design files
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// register byte offsets
`define SPC_REG_STRAP 8'h00
`define SPC_REG_PORT 8'h04
`define SPC_REG_LINK 8'h08
`define SPC_REG_SCRATCH 8'h0c
// strap register fields
`define SPC_STRAP_VC1 0
`define SPC_STRAP_POLDIS 1
`define SPC_STRAP_PL512 2
`define SPC_STRAP_SHCLK 3
`define SPC_STRAP_DONE 4
`define SPC_STRAP_RST 4'h8
// capture counter value at which synchronised straps are valid
`define SPC_CAP_LAST 2'h2
// port register field bases
`define SPC_PORT_PRES 1
`define SPC_PORT_SLOT 5
// payload size codes (bytes)
`define SPC_MPS_256 10'h100
`define SPC_MPS_512 10'h200
// port numbering
`define SPC_NPORT 3
`define SPC_UP_PORT 0
// reset values
`define SPC_LINK_RST 3'h0
`define SPC_SCRATCH_RST 32'h00000000
`endif

// ---- rtl/spc_sync.v ----
// spc_sync.v: two flip-flop synchroniser for a bundle of pin levels
// assumes pins are asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  // first stage read only by second stage
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // spc_sync
`default_nettype wire

// ---- rtl/spc_strap_cfg.v ----
// spc_strap_cfg.v: strap decode, slot status and port status outputs
// assumes straps and slot pins are board levels, async to ref_clk_i
// Functional notes
// R1: vc1 strap high enables vc1, no sharing
// R2: vc1 strap low pools vc1 buffers into vc0
// R3: polarity strap high disables inversion detection
// R4: payload strap high gives 512, else 256
// R5: presence pin low means device present
// R6: shared clock strap high reports platform clock
// R7: default is one shared platform reference clock
// R8: slot implemented marks slot, else chip-to-chip
// R9: one status output per port, ports 0..2
// R10: port 0 upstream, ports 1,2 downstream
// R11: reset clears all non-sticky state
// R12: straps captured at reset release, held
// R13: port status high when link is up
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
module spc_strap_cfg (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire vchan1_enable_strap_i,
  input wire rx_polarity_detect_disable_i,
  input wire large_payload_strap_i,
  input wire shared_refclk_strap_i,
  input wire [2:1] slot_present_n_i,
  input wire [2:1] slot_implemented_i,
  input wire [2:0] link_up_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg vc1_enable_o,
  output reg vc0_pool_vc1_o,
  output reg rx_pol_detect_en_o,
  output reg [9:0] max_payload_o,
  output reg shared_refclk_o,
  output reg [2:1] dev_present_o,
  output reg [2:1] slot_port_o,
  output reg [2:0] port_status_o
);
  // reset patterns taken from the constant map; pin bundle width is set here
  localparam PIN_W = 11;
  localparam [2:0] LINK_RST = `SPC_LINK_RST;
  localparam [31:0] SCRATCH_RST = `SPC_SCRATCH_RST;

  // synchronised pin levels: straps then slot pins then link state;
  // every board level crosses two flip-flops before any decode reads
  // it, so a pin that moves near reset release cannot split a capture
  wire [PIN_W-1:0] pins_s;
  spc_sync #(
    .W(PIN_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i({link_up_i, slot_implemented_i, slot_present_n_i,
              shared_refclk_strap_i, large_payload_strap_i,
              rx_polarity_detect_disable_i, vchan1_enable_strap_i}),
    .sync_o(pins_s)
  );

  // named slices of the synchronised bundle
  wire [3:0] strap_s = pins_s[3:0];
  wire [2:1] pres_n_s = pins_s[5:4];
  wire [2:1] slot_s = pins_s[7:6];
  wire [2:0] link_s = pins_s[10:8];

  // capture window: stays open while the synchroniser refills after
  // reset release; closing it early would latch the reset zeros of the
  // second stage instead of the board straps
  reg [1:0] cap_cnt_q;
  reg cap_done_q;
  reg [3:0] strap_q;
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin // R11
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
      strap_q <= `SPC_STRAP_RST; // R7
    end else if (!cap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == `SPC_CAP_LAST) begin
        strap_q <= strap_s; // R12
        cap_done_q <= 1'b1;
      end
    end
  end

  // named views of the held strap set; they change only at reset and at capture
  wire vc1_held = strap_q[`SPC_STRAP_VC1];
  wire poldis_held = strap_q[`SPC_STRAP_POLDIS];
  wire bigpay_held = strap_q[`SPC_STRAP_PL512];
  wire shclk_held = strap_q[`SPC_STRAP_SHCLK];

  // virtual channel split: vc1 on with its own buffers, or vc1 off and
  // its buffer share pooled into vc0; outside reset exactly one is high
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      vc1_enable_o <= 1'b0;
      vc0_pool_vc1_o <= 1'b0;
    end else begin
      vc1_enable_o <= vc1_held; // R1
      vc0_pool_vc1_o <= ~vc1_held; // R2
    end
  end

  // receive polarity inversion detection stays on unless strapped off;
  // it also comes up on during reset, the safe side for a new link
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rx_pol_detect_en_o <= 1'b1;
    end else begin
      rx_pol_detect_en_o <= ~poldis_held; // R3
    end
  end

  // advertised payload capability in bytes; the small size is shown
  // until the strap is captured so no link ever sees the large one early
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      max_payload_o <= `SPC_MPS_256;
    end else begin
      max_payload_o <= bigpay_held ? `SPC_MPS_512
                                   : `SPC_MPS_256; // R4
    end
  end

  // shared reference clock report; the held strap set resets to the
  // shared setting, which is the default board arrangement
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      shared_refclk_o <= 1'b1; // R7
    end else begin
      shared_refclk_o <= shclk_held; // R6
    end
  end

  // per-port status; index 0 is upstream and has no slot pins, so only
  // the downstream indices build presence and slot logic
  genvar p;
  generate
    for (p = 0; p < `SPC_NPORT; p = p + 1) begin : g_port
      always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          port_status_o[p] <= LINK_RST[p];
        end else begin
          port_status_o[p] <= link_s[p]; // R9 R13
        end
      end
      if (p != `SPC_UP_PORT) begin : g_down // R10
        always @(posedge ref_clk_i) begin
          if (!resetn_i) begin
            dev_present_o[p] <= 1'b0;
            slot_port_o[p] <= 1'b0;
          end else begin
            dev_present_o[p] <= ~pres_n_s[p]; // R5
            slot_port_o[p] <= slot_s[p]; // R8
          end
        end
      end
    end
  endgenerate

  // wishbone slave: a request is taken while cyc and stb stand with ack
  // low; ack follows one cycle later and stands for exactly one cycle
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack high, while it
  // still holds address, selects and data
  wire wr_hit = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i &
                (wb_adr_i == `SPC_REG_SCRATCH);

  // scratch word, one byte lane per select bit; straps and status are
  // read-only, so this is the only state that software can change
  reg [31:0] scratch_q;
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          scratch_q[b*8 +: 8] <= SCRATCH_RST[b*8 +: 8];
        end else if (wr_hit && wb_sel_i[b]) begin
          scratch_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  endgenerate

  // read mux: unmapped offsets read zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    case (wb_adr_i)
      `SPC_REG_STRAP: begin
        rd_d[3:0] = strap_q;
        rd_d[`SPC_STRAP_DONE] = cap_done_q;
      end
      `SPC_REG_PORT: begin
        rd_d[`SPC_PORT_PRES +: 2] = dev_present_o;
        rd_d[`SPC_PORT_SLOT +: 2] = slot_port_o;
      end
      `SPC_REG_LINK: begin
        rd_d[2:0] = port_status_o;
      end
      `SPC_REG_SCRATCH: begin
        rd_d = scratch_q;
      end
      default: begin
        rd_d = 32'h0;
      end
    endcase
  end

  // registered answer: read data stands with ack and is zero otherwise
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h0;
    end
  end
endmodule // spc_strap_cfg
`default_nettype wire

// ---- sim/spc_strap_cfg_assertions.sv ----
// checker for spc_strap_cfg ports
// assumes bind to the design top
`timescale 1ns/1ps
`default_nettype none
module spc_chk (
  input wire logic ref_clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic vc1_enable_o, vc0_pool_vc1_o,
  input wire logic [9:0] max_payload_o,
  input wire logic [2:1] slot_present_n_i, slot_implemented_i,
  input wire logic [2:1] dev_present_o, slot_port_o,
  input wire logic [2:0] link_up_i, port_status_o
);
  logic [2:0] n_q;
  wire ok = n_q == 3'h7;
  // cycles since reset release, saturating
  always @(posedge ref_clk_i) n_q <= resetn_i ? n_q + {2'h0, !ok} : 3'h0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_vc_split:
    assert property (ok |-> vc1_enable_o ^ vc0_pool_vc1_o) else $error("vc");
  chk_cfg_held:
    assert property (ok |-> $stable({vc1_enable_o, max_payload_o}))
      else $error("held");
  chk_pay_code:
    assert property (max_payload_o inside {10'h100, 10'h200}) else $error("mps");
  chk_pres_lag:
    assert property (ok |-> dev_present_o == ~$past(slot_present_n_i, 3))
      else $error("pres");
  chk_slot_lag:
    assert property (ok |-> slot_port_o == $past(slot_implemented_i, 3))
      else $error("slot");
  chk_stat_lag:
    assert property (ok |-> port_status_o == $past(link_up_i, 3))
      else $error("stat");
  chk_ack_taken:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("pulse");
  cover property (ok && vc1_enable_o);
  cover property (max_payload_o == 10'h200);
  cover property (wb_ack_o);
endmodule // spc_chk
bind spc_strap_cfg spc_chk u_spc_chk (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .vc1_enable_o(vc1_enable_o),
  .vc0_pool_vc1_o(vc0_pool_vc1_o),
  .max_payload_o(max_payload_o),
  .slot_present_n_i(slot_present_n_i),
  .slot_implemented_i(slot_implemented_i),
  .dev_present_o(dev_present_o),
  .slot_port_o(slot_port_o),
  .link_up_i(link_up_i),
  .port_status_o(port_status_o)
);
`default_nettype wire

// ---- sim/spc_board.sv ----
// board straps and slot wiring
// assumes a pin pattern from the bench
`timescale 1ns/1ps
`default_nettype none
module spc_board (
  input wire logic ref_clk_i,
  input wire logic [10:0] pat_i,
  output logic [10:0] pins_o
);
  // board levels follow the pattern one cycle later
  always @(posedge ref_clk_i) pins_o <= pat_i;
endmodule // spc_board
`default_nettype wire

// ---- sim/spc_strap_cfg_tb.sv ----
// random strap and bus test
// assumes spc_board and the bound checker
`timescale 1ns/1ps
`default_nettype none
module spc_strap_cfg_tb;
  logic ref_clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, sel;
  logic [31:0] wb_dat_i, q, r;
  logic [10:0] pat, p;
  wire [10:0] pin;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, vc1_enable_o, vc0_pool_vc1_o, rx_pol_detect_en_o;
  wire shared_refclk_o, vchan1_enable_strap_i, rx_polarity_detect_disable_i;
  wire large_payload_strap_i, shared_refclk_strap_i;
  wire [2:1] slot_present_n_i, slot_implemented_i, dev_present_o, slot_port_o;
  wire [2:0] link_up_i, port_status_o;
  wire [9:0] max_payload_o;
  int err_count, comparisons, i, n;
  assign {link_up_i, slot_implemented_i, slot_present_n_i,
    shared_refclk_strap_i, large_payload_strap_i,
    rx_polarity_detect_disable_i, vchan1_enable_strap_i} = pin;
  // decoded outputs and port outputs gathered in compare order
  wire [13:0] cfg_o = {vc1_enable_o, vc0_pool_vc1_o, rx_pol_detect_en_o,
    max_payload_o, shared_refclk_o};
  wire [6:0] stat_o = {dev_present_o, slot_port_o, port_status_o};
  spc_board u_spc_board (
    .ref_clk_i(ref_clk_i),
    .pat_i(pat),
    .pins_o(pin)
  );
  spc_strap_cfg u_spc_strap_cfg (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .vchan1_enable_strap_i(vchan1_enable_strap_i),
    .rx_polarity_detect_disable_i(rx_polarity_detect_disable_i),
    .large_payload_strap_i(large_payload_strap_i),
    .shared_refclk_strap_i(shared_refclk_strap_i),
    .slot_present_n_i(slot_present_n_i),
    .slot_implemented_i(slot_implemented_i),
    .link_up_i(link_up_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .vc1_enable_o(vc1_enable_o),
    .vc0_pool_vc1_o(vc0_pool_vc1_o),
    .rx_pol_detect_en_o(rx_pol_detect_en_o),
    .max_payload_o(max_payload_o),
    .shared_refclk_o(shared_refclk_o),
    .dev_present_o(dev_present_o),
    .slot_port_o(slot_port_o),
    .port_status_o(port_status_o)
  );
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // decoded outputs expected from a strap set
  function automatic logic [31:0] cfg(input logic [3:0] s);
    return {s[0], !s[0], !s[1], s[2] ? 10'h200 : 10'h100, s[3]};
  endfunction
  // port register expected from presence and slot pin levels
  function automatic logic [31:0] port_exp(input logic [2:1] pn, sl);
    return {25'h0, sl, 2'h0, ~pn, 1'b0};
  endfunction
  // scratch word after a write through byte selects
  function automatic logic [31:0] lane_mix(input logic [31:0] o, d,
    input logic [3:0] m);
    for (int k = 0; k < 4; k++) begin
      if (m[k]) o[k*8 +: 8] = d[k*8 +: 8];
    end
    return o;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] m);
    @(posedge ref_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'h3, w, a, m, d};
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_i = 0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // hang guard well above the run length
  always @(posedge ref_clk_i) begin
    n++;
    if (n == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // corner straps first, then random sets
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
    r = 32'h628305a4;
    for (i = 0; i < 6; i++) begin
      r = nxt(r);
      p = i == 0 ? 11'h0 : i == 1 ? 11'h7ff : r[10:0];
      sel = i < 2 ? 4'hf : r[31:28];
      pat <= p;
      resetn_i <= 0;
      repeat (10) @(posedge ref_clk_i);
      #1 chk(cfg_o, 14'ha01);
      chk(stat_o, 0);
      @(posedge ref_clk_i) resetn_i <= 1;
      repeat (8) @(posedge ref_clk_i);
      pat <= ~p;
      repeat (6) @(posedge ref_clk_i);
      #1 chk(cfg_o, cfg(p[3:0]));
      chk(stat_o, {p[5:4], ~p[7:6], ~p[10:8]});
      // a write to a read-only register must be dropped
      wb(1, 8'h00, r, 4'hf);
      wb(0, 8'h00, 0, 4'hf);
      chk(q, {27'h1, p[3:0]});
      wb(0, 8'h04, 0, 4'hf);
      chk(q, port_exp(~p[5:4], ~p[7:6]));
      wb(0, 8'h08, 0, 4'hf);
      chk(q, {29'h0, ~p[10:8]});
      wb(1, 8'h0c, r, sel);
      wb(0, 8'h0c, 0, 4'hf);
      chk(q, lane_mix(32'h0, r, sel));
      wb(0, 8'h10, 0, 4'hf);
      chk(q, 0);
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule // spc_strap_cfg_tb
`default_nettype wire
